/* File: vspsf_top.sv */
`timescale 1ns/1ps
`default_nettype none
module vspsf_top #(
  parameter int          NUM_FIELDS   = 16,
  parameter int          IDX_W        = 4,
  parameter int          CANON_BITS   = 48,
  parameter int          ERR_IDX      = 0,
  parameter logic [31:0] UNSUP_ERR_NUM = 32'h0000_0001 // Arbitrary value
) (
  input  wire logic                    ref_clk,        // 10 MHz core clock
  input  wire logic                    reset,          // Sync, active high
  input  wire logic                    req_valid,      // Instruction offered
  input  wire vspsf_pkg::vspsf_req_t   req,            // Opcode and operands
  input  wire vspsf_pkg::vspsf_mode_t  mode,           // Core mode bits
  input  wire vspsf_pkg::vspsf_seg_t   seg,            // Destination segment
  output logic                         req_ready,      // Idle, takes request
  input  wire logic                    ptr_load_valid, // Successful pointer load
  input  wire logic [63:0]             ptr_load_addr,  // Loaded pointer
  input  wire logic                    ptr_clear,      // Drop current pointer
  input  wire logic                    fld_wr_en,      // Field content write
  input  wire logic [IDX_W-1:0]        fld_wr_idx,     // Field index
  input  wire logic [63:0]             fld_wr_data,    // Field value
  input  wire vspsf_pkg::vspsf_fw_t    fld_wr_width,   // Field width code
  output logic                         mem_wr_valid,   // Memory write pending
  output logic [63:0]                  mem_wr_addr,    // Linear address
  output logic [63:0]                  mem_wr_data,    // Write data
  output logic [3:0]                   mem_wr_bytes,   // Byte count
  input  wire logic                    mem_resp_valid, // Write finished
  input  wire logic                    mem_resp_pf,    // Page fault seen
  input  wire logic [31:0]             mem_resp_code,  // Page fault code
  output logic                         reg_wr_valid,   // Register result pulse
  output logic [63:0]                  reg_wr_data,    // Register result
  output logic                         done,           // Completion pulse
  output vspsf_pkg::vspsf_result_t     result,         // Outcome and flags
  output logic                         ptr_valid       // Current pointer valid
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    vspsf_pkg::vspsf_state_t                 st;
    vspsf_pkg::vspsf_req_t                   req;
    vspsf_pkg::vspsf_mode_t                  mode;
    vspsf_pkg::vspsf_seg_t                   seg;
    logic                                    ptr_valid;
    logic [63:0]                             ptr;
    logic [NUM_FIELDS-1:0][63:0]             fields;
    logic [NUM_FIELDS-1:0][1:0]              widths;
    logic                                    mem_valid;
    logic [63:0]                             mem_addr;
    logic [63:0]                             mem_data;
    logic [3:0]                              mem_bytes;
    logic                                    reg_valid;
    logic [63:0]                             reg_data;
    logic                                    done;
    vspsf_pkg::vspsf_result_t                res;
  } vspsf_state_all_t;

  vspsf_state_all_t s_q;
  vspsf_state_all_t s_d;

  // ************************************************************
  // Decode and ordered checks on the latched request
  // ************************************************************
  logic             kind_store;
  logic             kind_read;
  logic             long64;
  logic             chk_ud;
  logic             chk_exit;
  logic             chk_gp;
  logic [IDX_W-1:0] fidx;
  logic [63:0]      sel_eff;
  logic             sel_ok;
  logic [63:0]      raw;
  logic [63:0]      masked;
  logic [63:0]      rd_value;
  logic [3:0]       acc_bytes;
  logic [32:0]      acc_end;
  logic             limit_bad;
  logic             canon_ok;
  logic             fault_gp;
  logic             fault_ss;

  // Store needs ModRM /7; the read is plain 0F 78
  assign kind_store = (s_q.req.opc2 == vspsf_pkg::OPC_STORE) &&
                      (s_q.req.modrm_reg == vspsf_pkg::MODRM_STORE);
  assign kind_read  = (s_q.req.opc2 == vspsf_pkg::OPC_READ);
  assign long64     = s_q.mode.lma && s_q.mode.cs_l;

  // Undefined opcode; only the store looks at protection enable
  assign chk_ud = !s_q.mode.in_virt || s_q.mode.v86 ||
                  (s_q.mode.lma && !s_q.mode.cs_l) ||
                  (kind_store && (s_q.req.op_is_reg || !s_q.mode.pe));
  assign chk_exit = s_q.mode.non_root;
  assign chk_gp   = (s_q.mode.priv != vspsf_pkg::PRIV_ROOT);

  // Selector: upper half ignored outside 64-bit mode, checked inside
  assign sel_eff = long64 ? s_q.req.sel : {32'h0000_0000, s_q.req.sel[31:0]};
  assign sel_ok  = ((sel_eff >> IDX_W) == 64'h0) &&
                   (64'(sel_eff[IDX_W-1:0]) < 64'(NUM_FIELDS));
  assign fidx    = sel_eff[IDX_W-1:0];
  assign raw     = s_q.fields[fidx];

  // Trim to field width, then to operand size; upper bits come out zero
  always_comb
  begin
    case (vspsf_pkg::vspsf_fw_t'(s_q.widths[fidx]))
      vspsf_pkg::FW_16: masked = {48'h0000_0000_0000, raw[15:0]};
      vspsf_pkg::FW_32: masked = {32'h0000_0000, raw[31:0]};
      default:          masked = raw;
    endcase
  end
  assign rd_value = long64 ? masked : {32'h0000_0000, masked[31:0]};

  // Segment and canonical checks on the destination
  assign acc_bytes = (kind_store || long64) ? vspsf_pkg::BYTES_64
                                            : vspsf_pkg::BYTES_32;
  assign acc_end   = {1'h0, s_q.req.ea[31:0]} + {29'h0000_0000, acc_bytes} - 33'h0_0000_0001;
  assign limit_bad = acc_end > {1'h0, s_q.seg.limit};
  assign canon_ok  = (&s_q.req.ea[63:CANON_BITS-1]) || !(|s_q.req.ea[63:CANON_BITS-1]);

  // Type faults take precedence; limit and unusable split on stack base
  always_comb
  begin
    fault_gp = 1'h0;
    fault_ss = 1'h0;
    if (long64)
    begin
      fault_ss = !canon_ok && s_q.seg.is_stack;
      fault_gp = !canon_ok && !s_q.seg.is_stack;
    end
    else if (s_q.seg.read_only || s_q.seg.code)
      fault_gp = 1'h1;
    else if (s_q.seg.unusable || limit_bad)
    begin
      fault_ss = s_q.seg.is_stack;
      fault_gp = !s_q.seg.is_stack;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d           = s_q;
    s_d.done      = 1'h0;
    s_d.reg_valid = 1'h0;

    // Field contents arrive from the write side of the structure
    if (fld_wr_en)
    begin
      s_d.fields[fld_wr_idx] = fld_wr_data;
      s_d.widths[fld_wr_idx] = fld_wr_width;
    end

    // Load wins over clear so a pointer load is never lost
    if (ptr_clear)
      s_d.ptr_valid = 1'h0;
    if (ptr_load_valid)
    begin
      s_d.ptr_valid = 1'h1;
      s_d.ptr       = ptr_load_addr;
    end

    case (s_q.st)
      vspsf_pkg::ST_IDLE:
      begin
        // Mode and segment are frozen with the request
        if (req_valid)
        begin
          s_d.req  = req;
          s_d.mode = mode;
          s_d.seg  = seg;
          s_d.st   = vspsf_pkg::ST_CHECK;
        end
      end
      vspsf_pkg::ST_CHECK:
      begin
        s_d.st           = vspsf_pkg::ST_IDLE;
        s_d.done         = 1'h1;
        s_d.res.flags    = vspsf_pkg::FLAGS_CLR;
        s_d.res.err_code = vspsf_pkg::ERR_ZERO;
        s_d.res.outcome  = vspsf_pkg::OC_SUCCESS;
        if (!kind_store && !kind_read)
          s_d.res.outcome = vspsf_pkg::OC_NONE;
        else if (chk_ud)
          s_d.res.outcome = vspsf_pkg::OC_UD;
        else if (chk_exit)
          s_d.res.outcome = vspsf_pkg::OC_EXIT;
        else if (chk_gp)
          s_d.res.outcome = vspsf_pkg::OC_GP;
        else if (kind_read && !s_q.ptr_valid)
        begin
          s_d.res.outcome    = vspsf_pkg::OC_FAIL_INV;
          s_d.res.flags.cf_f = 1'h1;
        end
        else if (kind_read && !sel_ok)
        begin
          // Error number lands in the structure; overrides a same-cycle write
          s_d.res.outcome       = vspsf_pkg::OC_FAIL_VAL;
          s_d.res.flags.zf_f    = 1'h1;
          s_d.fields[ERR_IDX]   = {32'h0000_0000, UNSUP_ERR_NUM};
          s_d.widths[ERR_IDX]   = vspsf_pkg::FW_32;
        end
        else if (kind_read && s_q.req.op_is_reg)
        begin
          s_d.reg_valid = 1'h1;
          s_d.reg_data  = rd_value;
        end
        else if (fault_ss)
          s_d.res.outcome = vspsf_pkg::OC_SS;
        else if (fault_gp)
          s_d.res.outcome = vspsf_pkg::OC_GP;
        else
        begin
          // Memory write; completion waits for the response
          s_d.done      = 1'h0;
          s_d.st        = vspsf_pkg::ST_MEM;
          s_d.mem_valid = 1'h1;
          s_d.mem_addr  = s_q.req.ea;
          s_d.mem_bytes = acc_bytes;
          s_d.mem_data  = kind_store ? s_q.ptr : rd_value;
        end
      end
      vspsf_pkg::ST_MEM:
      begin
        if (mem_resp_valid)
        begin
          s_d.mem_valid = 1'h0;
          s_d.st        = vspsf_pkg::ST_IDLE;
          s_d.done      = 1'h1;
          if (mem_resp_pf)
          begin
            s_d.res.outcome  = vspsf_pkg::OC_PF;
            s_d.res.err_code = mem_resp_code;
          end
          else
            s_d.res.outcome = vspsf_pkg::OC_SUCCESS;
        end
      end
      default:
        s_d.st = vspsf_pkg::ST_IDLE;
    endcase
  end

  // ************************************************************
  // Register
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q              <= '0;
      s_q.st           <= vspsf_pkg::ST_IDLE;
      s_q.ptr          <= vspsf_pkg::PTR_RST;
      s_q.res.outcome  <= vspsf_pkg::OC_NONE;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from the state
  assign req_ready    = (s_q.st == vspsf_pkg::ST_IDLE);
  assign mem_wr_valid = s_q.mem_valid;
  assign mem_wr_addr  = s_q.mem_addr;
  assign mem_wr_data  = s_q.mem_data;
  assign mem_wr_bytes = s_q.mem_bytes;
  assign reg_wr_valid = s_q.reg_valid;
  assign reg_wr_data  = s_q.reg_data;
  assign done         = s_q.done;
  assign result       = s_q.res;
  assign ptr_valid    = s_q.ptr_valid;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic in_check;
  assign in_check = (s_q.st == vspsf_pkg::ST_CHECK);

  property p_store_data;
    in_check && kind_store && !chk_ud && !chk_exit && !chk_gp && !fault_gp && !fault_ss
      |=> mem_wr_valid && (mem_wr_data == $past(s_q.ptr));
  endproperty
  a_store_data: assert property (p_store_data) else $error("store data wrong");

  property p_store_size;
    in_check && kind_store |=> !mem_wr_valid || (mem_wr_bytes == vspsf_pkg::BYTES_64);
  endproperty
  a_store_size: assert property (p_store_size) else $error("store size wrong");

  property p_reg_ud;
    in_check && kind_store && s_q.req.op_is_reg
      |=> done && (result.outcome == vspsf_pkg::OC_UD);
  endproperty
  a_reg_ud: assert property (p_reg_ud) else $error("register store not undefined");

  property p_exit;
    in_check && (kind_store || kind_read) && !chk_ud && s_q.mode.non_root
      |=> done && (result.outcome == vspsf_pkg::OC_EXIT) && !mem_wr_valid;
  endproperty
  a_exit: assert property (p_exit) else $error("missing monitor exit");

  property p_priv;
    in_check && kind_read && !chk_ud && !chk_exit && chk_gp
      |=> (result.outcome == vspsf_pkg::OC_GP) && (result.err_code == vspsf_pkg::ERR_ZERO);
  endproperty
  a_priv: assert property (p_priv) else $error("privilege fault wrong");

  property p_ss_code;
    done && (result.outcome == vspsf_pkg::OC_SS) |-> result.err_code == vspsf_pkg::ERR_ZERO;
  endproperty
  a_ss_code: assert property (p_ss_code) else $error("stack fault code nonzero");

  property p_pf;
    (s_q.st == vspsf_pkg::ST_MEM) && mem_resp_valid && mem_resp_pf
      |=> done && (result.outcome == vspsf_pkg::OC_PF) &&
          (result.err_code == $past(mem_resp_code));
  endproperty
  a_pf: assert property (p_pf) else $error("page fault not reported");

  property p_v86_read;
    in_check && kind_read && s_q.mode.v86 |=> result.outcome == vspsf_pkg::OC_UD;
  endproperty
  a_v86_read: assert property (p_v86_read) else $error("v86 read executed");

  property p_size32;
    reg_wr_valid && !$past(long64) |-> reg_wr_data[63:32] == 32'h0000_0000;
  endproperty
  a_size32: assert property (p_size32) else $error("upper half not zero");

  property p_fault_order;
    in_check && kind_read && (!s_q.ptr_valid || !sel_ok) && !chk_ud && !chk_exit && !chk_gp
      |=> done && !mem_wr_valid && (result.outcome != vspsf_pkg::OC_GP) &&
          (result.outcome != vspsf_pkg::OC_SS);
  endproperty
  a_fault_order: assert property (p_fault_order) else $error("memory fault too early");

  property p_fail_inv;
    done && (result.outcome == vspsf_pkg::OC_FAIL_INV)
      |-> result.flags == vspsf_flags_cf();
  endproperty
  a_fail_inv: assert property (p_fail_inv) else $error("invalid fail flags");

  property p_ptr_set;
    $rose(ptr_valid) |-> $past(ptr_load_valid);
  endproperty
  a_ptr_set: assert property (p_ptr_set) else $error("pointer valid without load");

  property p_success_flags;
    done && (result.outcome == vspsf_pkg::OC_SUCCESS) |-> result.flags == vspsf_pkg::FLAGS_CLR;
  endproperty
  a_success_flags: assert property (p_success_flags) else $error("success flags set");

  property p_mem_hold;
    mem_wr_valid && !mem_resp_valid |=> mem_wr_valid ##0 !done;
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory write dropped");

  function automatic vspsf_pkg::vspsf_flags_t vspsf_flags_cf();
    vspsf_pkg::vspsf_flags_t f;
    f      = vspsf_pkg::FLAGS_CLR;
    f.cf_f = 1'h1;
    return f;
  endfunction

  c_store_ok: cover property (in_check && kind_store ##1 mem_wr_valid ##[1:20] done);
  c_read_reg: cover property (reg_wr_valid);
  c_fail_inv: cover property (done && (result.outcome == vspsf_pkg::OC_FAIL_INV));
  c_pf:       cover property (done && (result.outcome == vspsf_pkg::OC_PF));
endmodule // vspsf_top
`default_nettype wire

/* File: vspsf_pkg.sv */
// How it works
// - Store opcode writes the current structure pointer to memory, then reports success.
// - Store operand is always a 64-bit memory word; a register operand is undefined.
// - Store is undefined for register operand, outside mode, protection off, v86, compat.
// - Once mode checks pass, non-root operation exits to the monitor instead.
// - Root operation with privilege level above zero raises protection fault, code zero.
// - Outside 64-bit mode, a destination in read-only data or any code segment raises protection fault.
// - Outside 64-bit mode, data limit overrun gives protection fault; stack overrun or unusable gives stack fault.
// - In 64-bit mode, non-canonical addresses fault: stack fault if stack based.
// - A page fault on the destination is reported with its fault code.
// - Both operations are undefined in v86, compatibility mode and outside the mode.
// - Field read takes its selector from a register, writes register or memory.
// - Selector is 32 bits outside long mode; 64-bit mode rejects nonzero bits 63:32.
// - Read destination is 32 bits outside long mode and 64 bits in 64-bit mode.
// - Narrow fields are zero extended; wide fields deliver only their low part.
// - Read memory faults come only after pointer valid and field supported.
// - Read is undefined outside mode, in v86, or compat; no protection-enable check.
// - Read without a valid pointer reports failure carrying no error number.
// - Unknown selector fails with unsupported error number; otherwise value lands, success.
// - Pointer and its valid mark are set only by a successful pointer load.
`default_nettype none
package vspsf_pkg;
  // ************************************************************
  // Opcode decode and fixed values
  // ************************************************************
  localparam logic [7:0]  OPC_STORE   = 8'hC7; // Second byte after 0F
  localparam logic [2:0]  MODRM_STORE = 3'h7;  // ModRM reg field of the store
  localparam logic [7:0]  OPC_READ    = 8'h78; // Second byte after 0F
  localparam logic [1:0]  PRIV_ROOT   = 2'h0;
  localparam logic [3:0]  BYTES_32    = 4'h4;
  localparam logic [3:0]  BYTES_64    = 4'h8;
  localparam logic [63:0] PTR_RST     = 64'h0;
  localparam logic [31:0] ERR_ZERO    = 32'h0;
  localparam logic [5:0]  FLAGS_CLR   = 6'h00;

  typedef enum logic [1:0] {FW_16 = 2'h0, FW_32 = 2'h1, FW_64 = 2'h2} vspsf_fw_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_CHECK = 3'h2,
    ST_MEM   = 3'h4
  } vspsf_state_t;

  typedef enum logic [3:0] {
    OC_NONE, OC_SUCCESS, OC_FAIL_INV, OC_FAIL_VAL,
    OC_UD, OC_GP, OC_SS, OC_PF, OC_EXIT
  } vspsf_outcome_t;

  typedef struct packed {
    logic of_f; logic sf_f; logic zf_f; logic af_f; logic pf_f; logic cf_f;
  } vspsf_flags_t;

  typedef struct packed {
    logic       in_virt;  // Inside virtualization_extension operation
    logic       non_root; // Guest side
    logic       pe;       // protection_enable_bit
    logic       v86;      // virtual_8086_flag
    logic       lma;      // long_mode_active
    logic       cs_l;     // Code segment long bit
    logic [1:0] priv;     // current_privilege_level
  } vspsf_mode_t;

  typedef struct packed {
    logic        is_stack;
    logic        unusable;
    logic        read_only;
    logic        code;
    logic [31:0] limit;
  } vspsf_seg_t;

  typedef struct packed {
    logic [7:0]  opc2;
    logic [2:0]  modrm_reg;
    logic        op_is_reg; // Destination operand is a register
    logic [63:0] sel;
    logic [63:0] ea;
  } vspsf_req_t;

  typedef struct packed {
    vspsf_outcome_t outcome;
    vspsf_flags_t   flags;
    logic [31:0]    err_code;
  } vspsf_result_t;
endpackage
`default_nettype wire

/* File: vspsf_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vspsf_mem_model (
  input  wire logic        ref_clk,        // Core clock
  input  wire logic        reset,          // Sync, active high
  input  wire logic        mem_wr_valid,   // Write pending
  input  wire logic [63:0] mem_wr_addr,    // Linear address
  input  wire logic [63:0] mem_wr_data,    // Write data
  input  wire logic [3:0]  mem_wr_bytes,   // Byte count
  input  wire logic [3:0]  dly,            // Cycles before answering
  input  wire logic        pf_cmd,         // Answer with a page fault
  input  wire logic [31:0] pf_code,        // Fault code to return
  output logic             mem_resp_valid, // Answer pulse
  output logic             mem_resp_pf,    // Page fault seen
  output logic [31:0]      mem_resp_code,  // Page fault code
  output logic [63:0]      last_addr,      // Address of last write
  output logic [63:0]      last_data,      // Data of last write
  output logic [3:0]       last_bytes      // Size of last write
);
  // ************************************************************
  // Memory answering writes
  // ************************************************************
  logic [3:0] cnt_q;
  logic       sent_q;

  // One answer per write; fault fields churn outside an answer so nothing reads stale values
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt_q          <= 4'h0;
      sent_q         <= 1'h0;
      mem_resp_valid <= 1'h0;
      mem_resp_pf    <= 1'h0;
      mem_resp_code  <= 32'h0;
      last_addr      <= 64'h0;
      last_data      <= 64'h0;
      last_bytes     <= 4'h0;
    end
    else
    begin
      mem_resp_valid <= 1'h0;
      mem_resp_pf    <= ~mem_resp_pf;
      mem_resp_code  <= ~mem_resp_code;
      if (!mem_wr_valid)
      begin
        cnt_q  <= 4'h0;
        sent_q <= 1'h0;
      end
      else if (!sent_q && cnt_q == dly)
      begin
        mem_resp_valid <= 1'h1;
        mem_resp_pf    <= pf_cmd;
        mem_resp_code  <= pf_cmd ? pf_code : ~pf_code;
        sent_q         <= 1'h1;
        last_addr      <= mem_wr_addr;
        last_data      <= mem_wr_data;
        last_bytes     <= mem_wr_bytes;
      end
      else if (!sent_q)
      begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // vspsf_mem_model
`default_nettype wire

/* File: vspsf_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vspsf_tb;
  // ************************************************************
  // Stimulus and checking
  // ************************************************************
  localparam logic [7:0]  OPS = vspsf_pkg::OPC_STORE;
  localparam logic [7:0]  OPR = vspsf_pkg::OPC_READ;
  localparam logic [63:0] PTR = 64'h0000_0012_3456_7000;
  localparam logic [63:0] D64 = 64'h1122_3344_5566_7788;
  localparam vspsf_pkg::vspsf_mode_t M64 = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 2'h0};
  localparam vspsf_pkg::vspsf_seg_t  SD  = '{1'h0, 1'h0, 1'h0, 1'h0, 32'hFFFF_FFFF};
  logic ref_clk, reset, req_valid, req_ready, ptr_load_valid, ptr_clear, fld_wr_en, rv;
  logic mem_wr_valid, mem_resp_valid, mem_resp_pf, reg_wr_valid, done, ptr_valid, pf_cmd;
  logic [63:0] ptr_load_addr, fld_wr_data, mem_wr_addr, mem_wr_data, reg_wr_data;
  logic [63:0] last_addr, last_data;
  logic [31:0] mem_resp_code, pf_code;
  logic [3:0]  fld_wr_idx, mem_wr_bytes, last_bytes, dly;
  vspsf_pkg::vspsf_req_t    req;
  vspsf_pkg::vspsf_mode_t   mode, m;
  vspsf_pkg::vspsf_seg_t    seg, s;
  vspsf_pkg::vspsf_fw_t     fld_wr_width;
  vspsf_pkg::vspsf_result_t result;
  int err_total, checks_done;

  vspsf_top uut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .mode(mode), .seg(seg), .req_ready(req_ready), .ptr_load_valid(ptr_load_valid),
    .ptr_load_addr(ptr_load_addr), .ptr_clear(ptr_clear), .fld_wr_en(fld_wr_en),
    .fld_wr_idx(fld_wr_idx), .fld_wr_data(fld_wr_data), .fld_wr_width(fld_wr_width),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_bytes(mem_wr_bytes), .mem_resp_valid(mem_resp_valid), .mem_resp_pf(mem_resp_pf),
    .mem_resp_code(mem_resp_code), .reg_wr_valid(reg_wr_valid), .reg_wr_data(reg_wr_data),
    .done(done), .result(result), .ptr_valid(ptr_valid));
  vspsf_mem_model mem (.ref_clk(ref_clk), .reset(reset), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_bytes(mem_wr_bytes),
    .dly(dly), .pf_cmd(pf_cmd), .pf_code(pf_code), .mem_resp_valid(mem_resp_valid),
    .mem_resp_pf(mem_resp_pf), .mem_resp_code(mem_resp_code), .last_addr(last_addr),
    .last_data(last_data), .last_bytes(last_bytes));

  // 10 MHz core clock
  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // Offer one instruction and wait, bounded, for its completion pulse
  task automatic run(input logic [7:0] opc, input logic rg, input logic [63:0] sel,
                     input logic [63:0] ea);
    int n;
    n = 0;
    req_valid <= 1'h1;
    req       <= '{opc, vspsf_pkg::MODRM_STORE, rg, sel, ea};
    mode      <= m;
    seg       <= s;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    @(negedge ref_clk);
    chk("req_ready", 64'h0, 64'(req_ready));
    while (n < 40)
    begin
      @(negedge ref_clk);
      n = (done === 1'h1) ? 99 : n + 1;
    end
    if (n != 99)
    begin
      err_total++;
      close_out();
    end
    rv = reg_wr_valid;
    @(posedge ref_clk);
  endtask

  task automatic ex(input vspsf_pkg::vspsf_outcome_t oc, input logic [5:0] fl,
                    input logic [31:0] er);
    chk("outcome", 64'(oc), 64'(result.outcome));
    chk("flags", 64'(fl), 64'(result.flags));
    chk("err_code", 64'(er), 64'(result.err_code));
  endtask

  // Field contents are loaded ahead of reads; the caller lowers the enable
  task automatic fld(input logic [3:0] idx, input logic [63:0] d, input vspsf_pkg::vspsf_fw_t w);
    fld_wr_en    <= 1'h1;
    fld_wr_idx   <= idx;
    fld_wr_data  <= d;
    fld_wr_width <= w;
    @(posedge ref_clk);
  endtask

  // Main sequence: pointer and store first, then mode order, then field sizing, then operand faults
  initial
  begin
    {req_valid, ptr_load_valid, ptr_clear, fld_wr_en, pf_cmd, rv} = '0;
    {req, ptr_load_addr, fld_wr_idx, fld_wr_data, pf_code, dly} = '0;
    fld_wr_width = vspsf_pkg::FW_16;
    mode = M64;
    seg = SD;
    m = M64;
    s = SD;
    err_total = 0;
    checks_done = 0;
    reset = 1'h1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    chk("ptr_valid", 64'h0, 64'(ptr_valid));
    run(OPR, 1'h1, 64'h0, 64'h0);
    ex(vspsf_pkg::OC_FAIL_INV, 6'h01, 32'h0);
    ptr_load_valid <= 1'h1;
    ptr_load_addr  <= PTR;
    fld(4'h2, D64, vspsf_pkg::FW_16);
    ptr_load_valid <= 1'h0;
    fld(4'h3, D64, vspsf_pkg::FW_64);
    fld_wr_en <= 1'h0;
    run(OPS, 1'h0, 64'h0, 64'h1000);
    ex(vspsf_pkg::OC_SUCCESS, 6'h00, 32'h0);
    chk("ptr_valid", 64'h1, 64'(ptr_valid));
    chk("mem_addr", 64'h1000, last_addr);
    chk("mem_data", PTR, last_data);
    chk("mem_bytes", 64'h8, 64'(last_bytes));
    pf_cmd  <= 1'h1;
    pf_code <= 32'h0000_0006;
    dly     <= 4'h3;
    run(OPS, 1'h0, 64'h0, 64'h1000);
    ex(vspsf_pkg::OC_PF, 6'h00, 32'h6);
    pf_cmd <= 1'h0;
    for (int i = 0; i < 5; i++)
    begin
      m = M64;
      m.in_virt = (i != 0);
      m.pe = (i != 1);
      m.v86 = (i == 2);
      m.cs_l = (i != 3);
      run(OPS, i == 4, 64'h0, 64'h1000);
      ex(vspsf_pkg::OC_UD, 6'h00, 32'h0);
      run(OPR, 1'h1, 64'h0, 64'h0);
      ex((i == 1 || i == 4) ? vspsf_pkg::OC_SUCCESS : vspsf_pkg::OC_UD, 6'h00, 32'h0);
    end
    for (int j = 0; j < 2; j++)
    begin
      m = M64;
      m.priv = 2'h3;
      m.non_root = 1'h1;
      run(j ? OPR : OPS, j == 1, 64'h0, 64'h1000);
      ex(vspsf_pkg::OC_EXIT, 6'h00, 32'h0);
      m.non_root = 1'h0;
      run(j ? OPR : OPS, j == 1, 64'h0, 64'h1000);
      ex(vspsf_pkg::OC_GP, 6'h00, 32'h0);
    end
    m = M64;
    run(OPR, 1'h1, 64'h3, 64'h0);
    chk("reg_data", D64, reg_wr_data);
    chk("reg_wr_valid", 64'h1, 64'(rv));
    run(OPR, 1'h1, 64'h2, 64'h0);
    chk("reg_data", 64'h7788, reg_wr_data);
    run(OPR, 1'h1, 64'h1_0000_0003, 64'h0);
    ex(vspsf_pkg::OC_FAIL_VAL, 6'h08, 32'h0);
    run(OPR, 1'h1, 64'h0, 64'h0);
    chk("err_number", 64'h1, reg_wr_data);
    run(OPR + 8'h01, 1'h1, 64'h0, 64'h0);
    ex(vspsf_pkg::OC_NONE, 6'h00, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      s.is_stack = i[0];
      run(OPR, 1'h0, 64'h3, 64'h0000_8000_0000_0000);
      ex(i ? vspsf_pkg::OC_SS : vspsf_pkg::OC_GP, 6'h00, 32'h0);
    end
    m.lma = 1'h0;
    m.cs_l = 1'h0;
    run(OPR, 1'h1, 64'h1_0000_0003, 64'h0);
    chk("reg_data", 64'h5566_7788, reg_wr_data);
    for (int i = 0; i < 6; i++)
    begin
      s = SD;
      s.read_only = (i == 0);
      s.code = (i == 1);
      s.is_stack = (i == 3 || i == 4);
      s.unusable = (i == 4);
      s.limit = (i > 1) ? 32'h0000_0FFF : 32'hFFFF_FFFF;
      run(OPR, 1'h0, 64'h3, (i == 5) ? 64'hFFC : 64'hFFD);
      ex(i < 3 ? vspsf_pkg::OC_GP : (i < 5 ? vspsf_pkg::OC_SS : vspsf_pkg::OC_SUCCESS),
         6'h00, 32'h0);
    end
    chk("mem_data", 64'h5566_7788, last_data);
    chk("mem_bytes", 64'h4, 64'(last_bytes));
    chk("mem_addr", 64'hFFC, last_addr);
    chk("reg_wr_valid", 64'h0, 64'(rv));
    s = SD;
    s.read_only = 1'h1;
    run(OPR, 1'h0, 64'h10, 64'h100);
    ex(vspsf_pkg::OC_FAIL_VAL, 6'h08, 32'h0);
    ptr_clear <= 1'h1;
    @(posedge ref_clk);
    ptr_clear <= 1'h0;
    run(OPR, 1'h0, 64'h3, 64'h100);
    ex(vspsf_pkg::OC_FAIL_INV, 6'h01, 32'h0);
    chk("ptr_valid", 64'h0, 64'(ptr_valid));
    close_out();
  end
endmodule // vspsf_tb
`default_nettype wire
